// ==== src/spictl_top.sv ====
// SPI control, rate generation, minimal shifter and low power handling
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module spictl_top (
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_SYS_RST,
	// Register port
	input wire logic [1:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [7:0] O_RDATA,
	// SPI pins
	input wire logic I_SCK,
	output logic O_SCK,
	output logic O_SCK_OE,
	input wire logic I_MOSI,
	output logic O_MOSI,
	output logic O_MOSI_OE,
	input wire logic I_MISO,
	output logic O_MISO,
	output logic O_MISO_OE,
	input wire logic I_SS_N,
	// CPU state
	input wire logic I_CPU_IMASK,
	input wire logic I_HALT,
	// Requests to the CPU
	output logic O_IRQ,
	output logic O_WAKE_WAIT,
	output logic O_WAKE_HALT,
	output logic O_PINS_SPI
);
	// ==========================================================
	// State
	logic [7:0] ctrl;
	logic done_f, wcol_f, ovr_f, mode_fault_flag_f;
	logic sod, ssm, soft_select_level;
	logic stat_seen, mode_fault_flag_armed;
	logic [7:0] shreg, rxbuf;
	logic out_bit, busy, sck_lvl, halt_d, halt_ok;
	logic [4:0] edge_cnt;
	logic [6:0] tick;
	logic [1:0] sck_s, mosi_s, miso_s, ssn_s;
	logic sck_prev;
	logic [7:0] mrx;
	logic [1:0] cap_p, fin_p;

	// ==========================================================
	// Decode
	wire logic ie = ctrl[spictl_pkg::CR_IE];
	wire logic pe = ctrl[spictl_pkg::CR_PE];
	wire logic master_select_bit = ctrl[spictl_pkg::CR_MASTER_SELECT_BIT];
	wire logic clock_polarity = ctrl[spictl_pkg::CR_CLOCK_POLARITY];
	wire logic clock_phase = ctrl[spictl_pkg::CR_CLOCK_PHASE];
	wire logic ss_int = ssm ? soft_select_level : ssn_s[1];
	wire logic fault = pe & master_select_bit & ~ss_int;
	// Halt freezes all but a selected slave that was picked at entry
	wire logic run = ~I_HALT | (halt_ok & ~master_select_bit);
	wire logic wr_ok = I_WR & ~I_HALT;
	wire logic rd_ok = I_RD & ~I_HALT;
	wire logic wr_data = wr_ok & (I_ADDR == spictl_pkg::ADDR_DATA);
	wire logic wr_ctrl = wr_ok & (I_ADDR == spictl_pkg::ADDR_CTRL);
	wire logic wr_stat = wr_ok & (I_ADDR == spictl_pkg::ADDR_STAT);
	wire logic rd_data = rd_ok & (I_ADDR == spictl_pkg::ADDR_DATA);
	wire logic rd_stat = rd_ok & (I_ADDR == spictl_pkg::ADDR_STAT);
	// Data writes inhibited while done flag stands unseen
	wire logic load_ok = wr_data & ~busy & ~(done_f & ~stat_seen);
	wire logic collide = wr_data & busy;

	// ==========================================================
	// Master rate select; low bits only matter in master mode
	logic [6:0] half;
	always_comb begin
		case ({ctrl[spictl_pkg::CR_DIV2], ctrl[spictl_pkg::CR_R1], ctrl[spictl_pkg::CR_R0]})
			3'h4: half = spictl_pkg::HALF_DIV4;
			3'h0: half = spictl_pkg::HALF_DIV8;
			3'h1: half = spictl_pkg::HALF_DIV16;
			3'h6: half = spictl_pkg::HALF_DIV32;
			3'h2: half = spictl_pkg::HALF_DIV64;
			default: half = spictl_pkg::HALF_DIV128;
		endcase
	end

	// ==========================================================
	// Edge source: divider in master mode, synced pin in slave mode
	wire logic m_edge = busy & master_select_bit & run & (tick == half - 7'h01);
	wire logic s_edge = busy & ~master_select_bit & run & (sck_s[1] != sck_prev);
	wire logic sck_edge = m_edge | s_edge;
	wire logic rx_in = master_select_bit ? miso_s[1] : mosi_s[1];
	// Capture on odd edges for phase 0, even edges for phase 1
	wire logic capture = sck_edge & (edge_cnt[0] == clock_phase);
	wire logic last_edge = sck_edge & (edge_cnt == spictl_pkg::EDGES_PER_BYTE - 5'h01);
	wire logic slave_go = pe & ~master_select_bit & ~ss_int & ~busy & run;
	// Master ends its byte only once the late captured last bit is in
	wire logic done_evt = (last_edge & ~master_select_bit) | fin_p[1];

	// Pin synchronisers
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			sck_s <= 2'h0;
			mosi_s <= 2'h0;
			miso_s <= 2'h0;
			ssn_s <= 2'h3;
			sck_prev <= 1'b0;
		end else begin
			sck_s <= {sck_s[0], I_SCK};
			mosi_s <= {mosi_s[0], I_MOSI};
			miso_s <= {miso_s[0], I_MISO};
			ssn_s <= {ssn_s[0], I_SS_N};
			sck_prev <= sck_s[1];
		end
	end

	// Control register; fault wins over software, upper bits reset to 0
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			ctrl <= spictl_pkg::CTRL_RESET;
		end else if (fault) begin
			ctrl[spictl_pkg::CR_PE] <= 1'b0;
			ctrl[spictl_pkg::CR_MASTER_SELECT_BIT] <= 1'b0;
		end else if (wr_ctrl) begin
			ctrl <= I_WDATA;
			// Enable and master held off while a fault is unacknowledged
			if (mode_fault_flag_f & ~mode_fault_flag_armed) begin
				ctrl[spictl_pkg::CR_PE] <= 1'b0;
				ctrl[spictl_pkg::CR_MASTER_SELECT_BIT] <= 1'b0;
			end
		end
	end

	// Software bits of the status register
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			sod <= 1'b0;
			ssm <= 1'b0;
			soft_select_level <= 1'b0;
		end else if (wr_stat) begin
			sod <= I_WDATA[spictl_pkg::SR_SOD];
			ssm <= I_WDATA[spictl_pkg::SR_SSM];
			soft_select_level <= I_WDATA[spictl_pkg::SR_SSI];
		end
	end

	// Hardware flags: a set in the clearing cycle wins
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			done_f <= 1'b0;
			ovr_f <= 1'b0;
			wcol_f <= 1'b0;
			mode_fault_flag_f <= 1'b0;
		end else begin
			if (done_evt)
				done_f <= 1'b1;
			else if (stat_seen & (rd_data | wr_data))
				done_f <= 1'b0;
			if (done_evt & done_f)
				ovr_f <= 1'b1;
			else if (rd_stat)
				ovr_f <= 1'b0;
			if (collide)
				wcol_f <= 1'b1;
			else if (stat_seen & (rd_data | wr_data))
				wcol_f <= 1'b0;
			if (fault)
				mode_fault_flag_f <= 1'b1;
			else if (mode_fault_flag_armed & wr_ctrl)
				mode_fault_flag_f <= 1'b0;
		end
	end

	// Clearing sequence tracking: status read arms, data access or control write ends
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			stat_seen <= 1'b0;
			mode_fault_flag_armed <= 1'b0;
		end else begin
			stat_seen <= rd_stat ? (done_f | wcol_f) : (stat_seen & ~(rd_data | wr_data));
			mode_fault_flag_armed <= rd_stat ? mode_fault_flag_f : (mode_fault_flag_armed & ~wr_ctrl);
		end
	end

	// Shift engine; received byte stays in the shifter so an unloaded slave echoes it
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			shreg <= 8'h00;
			out_bit <= 1'b0;
			busy <= 1'b0;
			edge_cnt <= 5'h00;
			tick <= 7'h00;
		end else if (load_ok) begin
			shreg <= I_WDATA;
			out_bit <= I_WDATA[7];
			busy <= master_select_bit & pe;
			edge_cnt <= 5'h00;
			tick <= 7'h00;
		end else if (slave_go) begin
			busy <= 1'b1;
			out_bit <= shreg[7];
			edge_cnt <= 5'h00;
		end else if (busy & (~pe | (~master_select_bit & ss_int))) begin
			busy <= 1'b0; // Deselect or disable aborts the byte
		end else if (busy & run) begin
			tick <= m_edge ? 7'h00 : tick + 7'h01;
			if (sck_edge)
				edge_cnt <= edge_cnt + 5'h01;
			if (capture)
				shreg <= {shreg[6:0], rx_in};
			else if (sck_edge)
				out_bit <= shreg[7];
			if (last_edge)
				busy <= 1'b0;
		end
	end

	// Master receive: synced MISO trails the SCK pin by two cycles, so sample late
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			cap_p <= 2'h0;
			fin_p <= 2'h0;
			mrx <= 8'h00;
		end else begin
			cap_p <= {cap_p[0], capture & master_select_bit};
			fin_p <= {fin_p[0], last_edge & master_select_bit};
			if (cap_p[1])
				mrx <= {mrx[6:0], miso_s[1]};
		end
	end

	// Receive buffer keeps the first byte after the clear
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST)
			rxbuf <= 8'h00;
		else if (fin_p[1] & ~done_f)
			rxbuf <= cap_p[1] ? {mrx[6:0], miso_s[1]} : mrx;
		else if (last_edge & ~master_select_bit & ~done_f)
			rxbuf <= capture ? {shreg[6:0], rx_in} : shreg;
	end

	// SCK level: idle at polarity, toggled on each master edge
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST)
			sck_lvl <= 1'b0;
		else if (!busy || !master_select_bit)
			sck_lvl <= clock_polarity;
		else if (m_edge)
			sck_lvl <= ~sck_lvl;
	end

	// Halt entry: wake possible only if slave select was low then
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			halt_d <= 1'b0;
			halt_ok <= 1'b0;
		end else begin
			halt_d <= I_HALT;
			if (I_HALT & ~halt_d)
				halt_ok <= pe & ~master_select_bit & ~ss_int;
			else if (!I_HALT)
				halt_ok <= 1'b0;
		end
	end

	// ==========================================================
	// Registered outputs
	wire logic any_evt = done_f | mode_fault_flag_f | ovr_f;
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_IRQ <= 1'b0;
			O_WAKE_WAIT <= 1'b0;
			O_WAKE_HALT <= 1'b0;
			O_PINS_SPI <= 1'b0;
			O_SCK <= 1'b0;
			O_SCK_OE <= 1'b0;
			O_MOSI_OE <= 1'b0;
			O_MISO_OE <= 1'b0;
			O_RDATA <= 8'h00;
		end else begin
			O_IRQ <= ie & any_evt & ~I_CPU_IMASK;
			O_WAKE_WAIT <= ie & any_evt;
			O_WAKE_HALT <= I_HALT & halt_ok & ie & done_f;
			O_PINS_SPI <= pe;
			O_SCK <= sck_lvl;
			O_SCK_OE <= pe & master_select_bit;
			O_MOSI_OE <= pe & master_select_bit & ~sod;
			// Slave drives MISO only while selected, so slaves do not fight
			O_MISO_OE <= pe & ~master_select_bit & ~sod & ~ss_int;
			if (rd_ok) begin
				case (I_ADDR)
					spictl_pkg::ADDR_DATA: O_RDATA <= rxbuf;
					spictl_pkg::ADDR_CTRL: O_RDATA <= ctrl;
					spictl_pkg::ADDR_STAT: O_RDATA <= {done_f, wcol_f, ovr_f, mode_fault_flag_f,
						1'b0, sod, ssm, soft_select_level};
					default: O_RDATA <= 8'h00;
				endcase
			end else begin
				O_RDATA <= 8'h00;
			end
		end
	end

	// Serial data from the output flip-flop to whichever line the mode owns
	assign O_MOSI = out_bit;
	assign O_MISO = out_bit;

endmodule : spictl_top

`default_nettype wire

// ==== src/spictl_pkg.sv ====
// Package with register map, field positions and timing constants of the SPI control block
package spictl_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [1:0] ADDR_DATA = 2'h0;
	localparam logic [1:0] ADDR_CTRL = 2'h1;
	localparam logic [1:0] ADDR_STAT = 2'h2;
	// ==========================================================
	// Control register fields
	localparam int CR_IE = 7;
	localparam int CR_PE = 6;
	localparam int CR_DIV2 = 5;
	localparam int CR_MASTER_SELECT_BIT = 4;
	localparam int CR_CLOCK_POLARITY = 3;
	localparam int CR_CLOCK_PHASE = 2;
	localparam int CR_R1 = 1;
	localparam int CR_R0 = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// ==========================================================
	// Status register fields
	localparam int SR_DONE = 7;
	localparam int SR_WCOL = 6;
	localparam int SR_OVR = 5;
	localparam int SR_MODE_FAULT_FLAG = 4;
	localparam int SR_SOD = 2;
	localparam int SR_SSM = 1;
	localparam int SR_SSI = 0;
	// ==========================================================
	// Transfer framing
	localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
	// Half periods of SCK in CPU cycles, by {div2, rate_select_low}
	localparam logic [6:0] HALF_DIV4 = 7'h02;
	localparam logic [6:0] HALF_DIV8 = 7'h04;
	localparam logic [6:0] HALF_DIV16 = 7'h08;
	localparam logic [6:0] HALF_DIV32 = 7'h10;
	localparam logic [6:0] HALF_DIV64 = 7'h20;
	localparam logic [6:0] HALF_DIV128 = 7'h40;
endpackage : spictl_pkg

// ==== verification/spictl_asserts.sv ====
// Checker of the SPI control block port behaviour
`timescale 1ns/100ps
`default_nettype none
module spictl_asserts (
	// Clock, reset and inputs
	input wire logic I_SYS_CLK, I_SYS_RST, I_WR, I_RD, I_SCK, I_MOSI, I_MISO,
	input wire logic I_SS_N, I_CPU_IMASK, I_HALT,
	input wire logic [1:0] I_ADDR,
	input wire logic [7:0] I_WDATA, O_RDATA,
	// Design outputs
	input wire logic O_SCK, O_SCK_OE, O_MOSI, O_MOSI_OE, O_MISO, O_MISO_OE,
	input wire logic O_IRQ, O_WAKE_WAIT, O_WAKE_HALT, O_PINS_SPI
);
	// ==========================================
	// Shared clocking
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (I_SYS_RST);
	// Select held low while master, three samples to pass the synchroniser
	sequence s_fault;
		(O_SCK_OE && !I_SS_N) [*3];
	endsequence
	sequence s_tog;
		O_SCK_OE && $changed(O_SCK);
	endsequence
	AST_IRQ_GATE: assert property (O_IRQ |-> O_WAKE_WAIT && !$past(I_CPU_IMASK))
		else $error("irq while masked or without event");
	AST_IRQ_PASS: assert property (O_WAKE_WAIT && !$past(I_CPU_IMASK) |-> O_IRQ)
		else $error("unmasked event without irq");
	AST_HALT_DONE: assert property (O_WAKE_HALT |-> O_WAKE_WAIT && $past(I_HALT))
		else $error("halt wake without halt or event");
	AST_SCK_PE: assert property (O_SCK_OE |-> O_PINS_SPI)
		else $error("sck driven with pins not given to spi");
	AST_OE_EXCL: assert property (!(O_MOSI_OE && O_MISO_OE))
		else $error("both data outputs enabled");
	AST_MOSI_MASTER_SELECT_BIT: assert property (O_MOSI_OE |-> O_SCK_OE)
		else $error("mosi driven outside master mode");
	AST_FAULT: assert property (s_fault |-> ##[1:6] !O_SCK_OE && !O_PINS_SPI)
		else $error("select low in master mode did not fault");
	AST_SCK_RATE: assert property (s_tog |=> $stable(O_SCK))
		else $error("sck half period below two cycles");
	AST_RDATA: assert property (O_RDATA != 8'h00 |-> $past(I_RD))
		else $error("read data outside read answer cycle");
endmodule : spictl_asserts
bind spictl_top spictl_asserts spictl_asserts_i (.*);
`default_nettype wire

// ==== verification/spictl_slave_model.sv ====
// Behavioural SPI slave standing on the far side of the master link
`timescale 1ns/100ps
`default_nettype none
module spictl_slave_model (
	// Link and configuration
	input wire logic i_sck, i_ss_n, i_mosi, i_clock_polarity, i_clock_phase,
	input wire logic [7:0] i_tx,
	// Serial out and received byte
	output logic o_miso,
	output logic [7:0] o_rx
);
	int n = 0;
	initial o_miso = 1'b0;
	// Select loads the first bit for phase 0
	always @(negedge i_ss_n) begin
		n = 0;
		o_miso = i_tx[7];
	end
	// Released line shows the inverse, not a stale bit
	always @(posedge i_ss_n) o_miso = ~o_miso;
	// Every transition of the clock while selected
	always @(i_sck) begin
		if (i_ss_n === 1'b0) begin
			n = n + 1;
			if (n[0] != i_clock_phase) o_rx = {o_rx[6:0], i_mosi};
			else if ((n - i_clock_phase) < 16) o_miso = i_tx[7 - (n - i_clock_phase) / 2];
			else o_miso = ~o_miso;
		end
	end
endmodule : spictl_slave_model
`default_nettype wire

// ==== verification/spictl_top_tb_top.sv ====
// Self-checking bench of the SPI control block
`timescale 1ns/100ps
`default_nettype none
module spictl_top_tb_top;
	logic clk = 0, rst = 1, wr = 0, rd = 0, sck_m = 0, mosi_m = 0, ss_n = 1;
	logic imask = 0, halt = 0, slv_n = 1, mcp = 0, mph = 0;
	logic [1:0] adr = 0;
	logic [7:0] wd = 0, rdata, mtx = 0, prx, d, m, r, b1, b2;
	logic sck, sck_oe, mo, mo_oe, mi, mi_oe, irq, ww, wh, pins, pmiso;
	logic [7:0] q_rx[$];
	logic [2:0] cd [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
	int hf [6] = '{2, 4, 8, 16, 32, 64};
	int mismatches = 0, checks = 0, cyc = 0, seed = 25, t, k, ctl;
	// Wire levels from every party's enable
	wire w_sck = sck_oe ? sck : sck_m;
	wire w_mo = mo_oe ? mo : mosi_m;
	wire w_mi = mi_oe ? mi : pmiso;
	spictl_top spictl_top_i (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_ADDR(adr),
		.I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SCK(w_sck),
		.O_SCK(sck), .O_SCK_OE(sck_oe), .I_MOSI(w_mo), .O_MOSI(mo), .O_MOSI_OE(mo_oe),
		.I_MISO(w_mi), .O_MISO(mi), .O_MISO_OE(mi_oe), .I_SS_N(ss_n),
		.I_CPU_IMASK(imask), .I_HALT(halt), .O_IRQ(irq), .O_WAKE_WAIT(ww),
		.O_WAKE_HALT(wh), .O_PINS_SPI(pins));
	spictl_slave_model spictl_slave_model_i (.i_sck(w_sck), .i_ss_n(slv_n),
		.i_mosi(w_mo), .i_clock_polarity(mcp), .i_clock_phase(mph), .i_tx(mtx), .o_miso(pmiso), .o_rx(prx));
	// ==========================================
	// Clock, reset and hang limit
	initial forever #10 clk = ~clk;
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			stop_test;
		end
	end
	// ==========================================
	// Shared tasks
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task stop_test;
		$display("mismatches=%0d checks=%0d", mismatches, checks);
		if (mismatches == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : stop_test
	task wreg(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		adr <= a;
		wd <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task rreg(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask : rreg
	// Bench acts as master on the slave pins, phase 1, polarity 0
	task sb(input logic [7:0] b, output logic [7:0] q);
		for (int j = 7; j >= 0; j--) begin
			@(posedge clk);
			sck_m <= 1'b1;
			mosi_m <= b[j];
			repeat (8) @(negedge clk);
			q[j] = w_mi;
			@(posedge clk);
			sck_m <= 1'b0;
			repeat (8) @(posedge clk);
		end
	endtask : sb
	// ==========================================
	// Main sequence
	initial begin
		repeat (13) @(posedge clk);
		rreg(2'h1, r);
		chk(r & 8'hf0, 8'h00);
		wreg(2'h3, 8'hff);
		rreg(2'h3, r);
		chk(r, 8'h00);
		rreg(2'h1, r);
		chk(r, 8'h00);
		// All six rates and all four clock modes in master mode
		for (k = 0; k < 6; k++) begin
			ctl = {2'b10, cd[k][2], 1'b1, k[0], k[1], cd[k][1:0]};
			mcp <= k[0];
			mph <= k[1];
			wreg(2'h1, ctl[7:0]);
			ctl[6] = 1'b1;
			wreg(2'h1, ctl[7:0]);
			repeat (3) @(negedge clk);
			chk(sck, k[0]);
			d = $random(seed);
			m = $random(seed);
			mtx <= m;
			@(posedge clk);
			slv_n <= 1'b0;
			wreg(2'h0, d);
			t = 0;
			while (sck === k[0] && t < 300) begin
				@(negedge clk);
				t++;
			end
			t = 0;
			while (sck !== k[0] && t < 300) begin
				@(negedge clk);
				t++;
			end
			chk(t, hf[k]);
			t = 0;
			while (ww !== 1'b1 && t < 3000) begin
				@(negedge clk);
				t++;
			end
			rreg(2'h2, r);
			chk(r, 8'h80);
			rreg(2'h0, r);
			chk(r, m);
			chk(prx, d);
			slv_n <= 1'b1;
		end
		// Select pulled low while master
		ss_n <= 1'b0;
		repeat (8) @(negedge clk);
		chk(pins, 1'b0);
		chk(sck_oe, 1'b0);
		rreg(2'h2, r);
		chk(r, 8'h10);
		rreg(2'h1, r);
		chk(r, ctl & 8'haf);
		// Slave in HALT, rate bits set but ignored
		imask <= 1'b1;
		wreg(2'h1, 8'hc7);
		@(posedge clk);
		halt <= 1'b1;
		b1 = $random(seed);
		b2 = $random(seed);
		q_rx.push_back(b1);
		q_rx.push_back(b2);
		sb(b1, r);
		repeat (6) @(negedge clk);
		chk(wh, 1'b1);
		chk(irq, 1'b0);
		chk(ww, 1'b1);
		sb(b2, r);
		chk(r, q_rx[0]);
		repeat (6) @(posedge clk);
		halt <= 1'b0;
		imask <= 1'b0;
		repeat (3) @(negedge clk);
		chk(irq, 1'b1);
		rreg(2'h2, r);
		chk(r, 8'ha0);
		rreg(2'h0, r);
		chk(r, q_rx[0]);
		rreg(2'h2, r);
		chk(r, 8'h00);
		repeat (3) @(negedge clk);
		chk(irq, 1'b0);
		stop_test;
	end
endmodule : spictl_top_tb_top
`default_nettype wire
